/* File: verilog/acrm_regs.sv */
// accelerometer register bank behind the serial byte access port
// assumes the serial engines deliver decoded bytes on clk_in and hold busy over a transaction
`timescale 1ns/100ps
`default_nettype none
module acrm_regs
    import acrm_pkg::*;
#(
    parameter logic [7:0] PART_ID = 8'h5A  // arbitrary identification value
)(
    // clock and reset
    input  wire logic                          clk_in,
    input  wire logic                          srst_in,
    // serial byte access port
    input  wire logic                          acc_busy_in,
    input  wire logic                          acc_addr_load_in,
    input  wire logic [7:0]                    acc_addr_in,
    input  wire logic                          acc_wr_in,
    input  wire logic [BYTE_W-1:0]             acc_wdata_in,
    input  wire logic                          acc_rd_in,
    output logic [BYTE_W-1:0]                  acc_rdata_out,
    output logic                               acc_rvalid_out,
    // sensor core side
    input  wire logic                          smp_valid_in,
    input  wire logic [SAMPLE_W-1:0]           x_axis_sample_in,
    input  wire logic [SAMPLE_W-1:0]           y_axis_sample_in,
    input  wire logic [SAMPLE_W-1:0]           z_axis_sample_in,
    input  wire logic [BYTE_W-1:0]             evt_flags_in,
    input  wire logic [BYTE_W-1:0]             int_pend_in,
    input  wire logic [1:0]                    fifo_flags_in,
    input  wire logic [FIDX_W-1:0]             fifo_rd_idx_in,
    input  wire logic [FIDX_W-1:0]             fifo_wr_idx_in,
    input  wire logic                          wdt_event_in,
    input  wire logic                          otp_busy_in,
    // configuration towards the core
    output logic [BYTE_W-1:0]                  intr_enable_out,
    output logic [BYTE_W-1:0]                  power_state_out,
    output logic [BYTE_W-1:0]                  rate_select_out,
    output logic [BYTE_W-1:0]                  motion_ctrl_out,
    output logic [BYTE_W-1:0]                  range_filter_out,
    output logic [BYTE_W-1:0]                  x_offset_low_out
);
    import acrm_pkg::*;

    acrm_upd_if upd ();

    // hold stage for samples and event status
    acrm_hold u_hold (
        .clk_in       (clk_in),
        .srst_in      (srst_in),
        .busy_in      (acc_busy_in),
        .smp_valid_in (smp_valid_in),
        .x_in         (x_axis_sample_in),
        .y_in         (y_axis_sample_in),
        .z_in         (z_axis_sample_in),
        .evt_in       (evt_flags_in),
        .pend_in      (int_pend_in),
        .upd          (upd.src)
    );

    logic [7:0]          addr_reg,  addr_next;
    logic [BYTE_W-1:0]   ien_reg,   ien_next;
    logic [BYTE_W-1:0]   pwr_reg,   pwr_next;
    logic [BYTE_W-1:0]   rate_reg,  rate_next;
    logic [BYTE_W-1:0]   mot_reg,   mot_next;
    logic [BYTE_W-1:0]   rng_reg,   rng_next;
    logic [BYTE_W-1:0]   xoff_reg,  xoff_next;
    logic                wdt_reg,   wdt_next;
    logic [SAMPLE_W-1:0] xs_reg,    xs_next;
    logic [SAMPLE_W-1:0] ys_reg,    ys_next;
    logic [SAMPLE_W-1:0] zs_reg,    zs_next;
    logic [BYTE_W-1:0]   evt_reg,   evt_next;
    logic [BYTE_W-1:0]   pend_reg,  pend_next;
    logic [1:0]          ff_reg,    ff_next;
    logic [FIDX_W-1:0]   frd_reg,   frd_next;
    logic [FIDX_W-1:0]   fwr_reg,   fwr_next;
    logic [BYTE_W-1:0]   rdata_reg, rdata_next;
    logic                rvld_reg,  rvld_next;
    logic                wake;
    logic                wr_ok;
    logic [BYTE_W-1:0]   rd_mux;
    logic [BYTE_W-1:0]   device_status;

    // wake blocks all writes except to power state control
    assign wake  = (pwr_reg[1:0] == STATE_WAKE);
    assign wr_ok = acc_wr_in && (!wake || addr_reg == ADDR_POWER_STATE_CTRL);

    // device status byte assembled from live state
    always_comb begin
        device_status                  = RST_BYTE;
        device_status[DS_OTP_BUSY_BIT] = otp_busy_in;
        device_status[DS_WDT_BIT]      = wdt_reg;
        device_status[1:0]             = pwr_reg[1:0];
    end

    // read decode, low bytes carry bits 7..0
    always_comb begin
        case (addr_reg)
            ADDR_DEVICE_STATUS:    rd_mux = device_status;
            ADDR_EVENT_INT_ENABLE: rd_mux = ien_reg;
            ADDR_POWER_STATE_CTRL: rd_mux = pwr_reg;
            ADDR_OUTPUT_RATE_SEL:  rd_mux = rate_reg;
            ADDR_MOTION_FEAT_CTRL: rd_mux = mot_reg;
            ADDR_FIFO_LEVEL_FLAGS: rd_mux = {6'h00, ff_reg};
            ADDR_FIFO_READ_INDEX:  rd_mux = {2'h0, frd_reg};
            ADDR_FIFO_WRITE_INDEX: rd_mux = {2'h0, fwr_reg};
            ADDR_X_SAMPLE_LOW:     rd_mux = xs_reg[7:0];
            ADDR_X_SAMPLE_HIGH:    rd_mux = xs_reg[15:8];
            ADDR_Y_SAMPLE_LOW:     rd_mux = ys_reg[7:0];
            ADDR_Y_SAMPLE_HIGH:    rd_mux = ys_reg[15:8];
            ADDR_Z_SAMPLE_LOW:     rd_mux = zs_reg[7:0];
            ADDR_Z_SAMPLE_HIGH:    rd_mux = zs_reg[15:8];
            ADDR_EVENT_FLAGS:      rd_mux = evt_reg;
            ADDR_INTERRUPT_PEND:   rd_mux = pend_reg;
            ADDR_PART_IDENTIFIER:  rd_mux = PART_ID;
            ADDR_FULL_SCALE_SEL:   rd_mux = rng_reg;
            ADDR_X_OFFSET_LOW:     rd_mux = xoff_reg;
            default:               rd_mux = RST_BYTE;
        endcase
    end

    // next values of pointer, configuration, status and read answer
    always_comb begin
        addr_next  = addr_reg;
        ien_next   = ien_reg;
        pwr_next   = pwr_reg;
        rate_next  = rate_reg;
        mot_next   = mot_reg;
        rng_next   = rng_reg;
        xoff_next  = xoff_reg;
        wdt_next   = wdt_reg;
        xs_next    = xs_reg;
        ys_next    = ys_reg;
        zs_next    = zs_reg;
        evt_next   = evt_reg;
        pend_next  = pend_reg;
        ff_next    = ff_reg;
        frd_next   = frd_reg;
        fwr_next   = fwr_reg;
        rdata_next = rdata_reg;
        rvld_next  = 1'b0;
        // byte access from the serial engines
        if (acc_addr_load_in) begin
            addr_next = acc_addr_in;
        end else if (acc_wr_in || acc_rd_in) begin
            addr_next = addr_reg + 8'h01;
        end
        if (!acc_addr_load_in && acc_rd_in) begin
            rdata_next = rd_mux;
            rvld_next  = 1'b1;
            if (addr_reg == ADDR_DEVICE_STATUS) begin
                wdt_next = 1'b0;                           // cleared by reading status
            end
        end
        if (!acc_addr_load_in && wr_ok) begin
            case (addr_reg)
                ADDR_EVENT_INT_ENABLE: ien_next  = acc_wdata_in & WMASK_EVENT_INT_ENABLE;
                ADDR_POWER_STATE_CTRL: pwr_next  = acc_wdata_in & WMASK_POWER_STATE_CTRL;
                ADDR_OUTPUT_RATE_SEL:  rate_next = acc_wdata_in & WMASK_OUTPUT_RATE_SEL;
                ADDR_MOTION_FEAT_CTRL: mot_next  = acc_wdata_in & WMASK_MOTION_FEAT_CTRL;
                ADDR_FULL_SCALE_SEL:   rng_next  = acc_wdata_in & WMASK_FULL_SCALE_SEL;
                ADDR_X_OFFSET_LOW:     xoff_next = acc_wdata_in & WMASK_X_OFFSET_LOW;
                default:               ;
            endcase
        end
        // watchdog event wins over the clearing read
        if (wdt_event_in) begin
            wdt_next = 1'b1;
        end
        // held samples and event status
        if (upd.apply) begin
            xs_next   = upd.x_smp;
            ys_next   = upd.y_smp;
            zs_next   = upd.z_smp;
            evt_next  = upd.evt;
            pend_next = upd.pend;
        end
        // fifo status also frozen during a transaction
        if (!acc_busy_in) begin
            ff_next  = fifo_flags_in;
            frd_next = fifo_rd_idx_in;
            fwr_next = fifo_wr_idx_in;
        end
    end

    // register all state
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            addr_reg  <= RST_BYTE;
            ien_reg   <= RST_BYTE;
            pwr_reg   <= RST_BYTE;
            rate_reg  <= RST_BYTE;
            mot_reg   <= RST_BYTE;
            rng_reg   <= RST_BYTE;
            xoff_reg  <= RST_BYTE;
            wdt_reg   <= 1'b0;
            xs_reg    <= RST_WORD;
            ys_reg    <= RST_WORD;
            zs_reg    <= RST_WORD;
            evt_reg   <= RST_BYTE;
            pend_reg  <= RST_BYTE;
            ff_reg    <= 2'h0;
            frd_reg   <= '0;
            fwr_reg   <= '0;
            rdata_reg <= RST_BYTE;
            rvld_reg  <= 1'b0;
        end else begin
            addr_reg  <= addr_next;
            ien_reg   <= ien_next;
            pwr_reg   <= pwr_next;
            rate_reg  <= rate_next;
            mot_reg   <= mot_next;
            rng_reg   <= rng_next;
            xoff_reg  <= xoff_next;
            wdt_reg   <= wdt_next;
            xs_reg    <= xs_next;
            ys_reg    <= ys_next;
            zs_reg    <= zs_next;
            evt_reg   <= evt_next;
            pend_reg  <= pend_next;
            ff_reg    <= ff_next;
            frd_reg   <= frd_next;
            fwr_reg   <= fwr_next;
            rdata_reg <= rdata_next;
            rvld_reg  <= rvld_next;
        end
    end

    // outputs straight from flops
    assign acc_rdata_out    = rdata_reg;
    assign acc_rvalid_out   = rvld_reg;
    assign intr_enable_out  = ien_reg;
    assign power_state_out  = pwr_reg;
    assign rate_select_out  = rate_reg;
    assign motion_ctrl_out  = mot_reg;
    assign range_filter_out = rng_reg;
    assign x_offset_low_out = xoff_reg;

    property p_samples_frozen;
        @(posedge clk_in) disable iff (srst_in)
        acc_busy_in && !smp_valid_in |=> $stable(ys_reg) && $stable(evt_reg);
    endproperty
    a_samples_frozen: assert property (p_samples_frozen) else $error("sample changed in transaction");

    property p_y_low_read;
        @(posedge clk_in) disable iff (srst_in)
        (acc_rd_in && !acc_addr_load_in && addr_reg == ADDR_Y_SAMPLE_LOW)
        |=> acc_rvalid_out && acc_rdata_out == $past(ys_reg[7:0]);
    endproperty
    a_y_low_read: assert property (p_y_low_read) else $error("y low byte wrong");

    property p_y_high_read;
        @(posedge clk_in) disable iff (srst_in)
        (acc_rd_in && !acc_addr_load_in && addr_reg == ADDR_Y_SAMPLE_HIGH)
        |=> acc_rdata_out == $past(ys_reg[15:8]);
    endproperty
    a_y_high_read: assert property (p_y_high_read) else $error("y high byte wrong");

    property p_wake_write_block;
        @(posedge clk_in) disable iff (srst_in)
        (wake && acc_wr_in && !acc_addr_load_in && addr_reg == ADDR_OUTPUT_RATE_SEL)
        |=> $stable(rate_select_out);
    endproperty
    a_wake_write_block: assert property (p_wake_write_block) else $error("write taken in wake");

    property p_standby_write;
        @(posedge clk_in) disable iff (srst_in)
        (!wake && acc_wr_in && !acc_addr_load_in && addr_reg == ADDR_MOTION_FEAT_CTRL)
        |=> motion_ctrl_out == $past(acc_wdata_in);
    endproperty
    a_standby_write: assert property (p_standby_write) else $error("standby write lost");

    sequence s_byte_step;
        (acc_wr_in || acc_rd_in) && !acc_addr_load_in;
    endsequence
    property p_pointer_step;
        @(posedge clk_in) disable iff (srst_in)
        s_byte_step |=> addr_reg == 8'($past(addr_reg) + 8'h01);
    endproperty
    a_pointer_step: assert property (p_pointer_step) else $error("pointer did not advance");

    property p_reserved_zero;
        @(posedge clk_in) disable iff (srst_in)
        (acc_rd_in && !acc_addr_load_in && addr_reg < ADDR_DEVICE_STATUS)
        |=> acc_rdata_out == RST_BYTE;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved read not zero");

    property p_reserved_bits;
        @(posedge clk_in) disable iff (srst_in)
        rate_select_out[7:3] == 5'h00 && intr_enable_out[5] == 1'b0 && range_filter_out[7] == 1'b0;
    endproperty
    a_reserved_bits: assert property (p_reserved_bits) else $error("reserved bit set");

    property p_wdt_set_wins;
        @(posedge clk_in) disable iff (srst_in) wdt_event_in |=> wdt_reg;
    endproperty
    a_wdt_set_wins: assert property (p_wdt_set_wins) else $error("watchdog flag lost");
endmodule
`default_nettype wire

/* File: shared/acrm_pkg.sv */
// constants and types of the accelerometer register bank
// assumes one 200 MHz clock and a byte access port fed by the serial engines
// Contract
// - sample and event-status updates wait until the serial transaction has ended.
// - bit 0 of every byte register is its least significant bit.
// - host configures and monitors all registers through the serial byte port.
// - y sample bits 7..0 read-only at 0x0F, reset 0x00.
// - y sample bits 15..8 read-only at 0x10, after the low byte.
// - standby accepts all writes; wake accepts writes only to power state control.
// - register pointer advances by one after every byte read or written.
package acrm_pkg;
    // widths
    localparam int BYTE_W   = 8;
    localparam int SAMPLE_W = 16;
    localparam int FIDX_W   = 6;
    // register offsets
    localparam logic [7:0] ADDR_DEVICE_STATUS    = 8'h05;
    localparam logic [7:0] ADDR_EVENT_INT_ENABLE = 8'h06;
    localparam logic [7:0] ADDR_POWER_STATE_CTRL = 8'h07;
    localparam logic [7:0] ADDR_OUTPUT_RATE_SEL  = 8'h08;
    localparam logic [7:0] ADDR_MOTION_FEAT_CTRL = 8'h09;
    localparam logic [7:0] ADDR_FIFO_LEVEL_FLAGS = 8'h0A;
    localparam logic [7:0] ADDR_FIFO_READ_INDEX  = 8'h0B;
    localparam logic [7:0] ADDR_FIFO_WRITE_INDEX = 8'h0C;
    localparam logic [7:0] ADDR_X_SAMPLE_LOW     = 8'h0D;
    localparam logic [7:0] ADDR_X_SAMPLE_HIGH    = 8'h0E;
    localparam logic [7:0] ADDR_Y_SAMPLE_LOW     = 8'h0F;
    localparam logic [7:0] ADDR_Y_SAMPLE_HIGH    = 8'h10;
    localparam logic [7:0] ADDR_Z_SAMPLE_LOW     = 8'h11;
    localparam logic [7:0] ADDR_Z_SAMPLE_HIGH    = 8'h12;
    localparam logic [7:0] ADDR_EVENT_FLAGS      = 8'h13;
    localparam logic [7:0] ADDR_INTERRUPT_PEND   = 8'h14;
    localparam logic [7:0] ADDR_PART_IDENTIFIER  = 8'h18;
    localparam logic [7:0] ADDR_FULL_SCALE_SEL   = 8'h20;
    localparam logic [7:0] ADDR_X_OFFSET_LOW     = 8'h21;
    // reset values
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [15:0] RST_WORD  = 16'h0000;
    // writable bits of each read/write register, reserved bits stay zero
    localparam logic [7:0] WMASK_EVENT_INT_ENABLE = 8'hDF;
    localparam logic [7:0] WMASK_POWER_STATE_CTRL = 8'h33;
    localparam logic [7:0] WMASK_OUTPUT_RATE_SEL  = 8'h07;
    localparam logic [7:0] WMASK_MOTION_FEAT_CTRL = 8'hFF;
    localparam logic [7:0] WMASK_FULL_SCALE_SEL   = 8'h7F;
    localparam logic [7:0] WMASK_X_OFFSET_LOW     = 8'hFF;
    // device status field positions
    localparam int DS_OTP_BUSY_BIT = 7;
    localparam int DS_WDT_BIT      = 4;
    // operating state codes in power state control bits 1..0
    localparam logic [1:0] STATE_STANDBY = 2'h0;
    localparam logic [1:0] STATE_WAKE    = 2'h1;
    // update hold state
    typedef enum logic {HOLD_IDLE, HOLD_PENDING} acrm_hold_t;
endpackage

/* File: shared/acrm_upd_if.sv */
// carrier of held sample and event updates between hold stage and register bank
// assumes both ends sit on the same clock
`timescale 1ns/100ps
`default_nettype none
interface acrm_upd_if;
    import acrm_pkg::*;
    logic                apply;  // one-cycle pulse: load the values below
    logic [SAMPLE_W-1:0] x_smp;
    logic [SAMPLE_W-1:0] y_smp;
    logic [SAMPLE_W-1:0] z_smp;
    logic [BYTE_W-1:0]   evt;
    logic [BYTE_W-1:0]   pend;
    modport src (output apply, x_smp, y_smp, z_smp, evt, pend);
    modport dst (input  apply, x_smp, y_smp, z_smp, evt, pend);
endinterface
`default_nettype wire

/* File: verilog/acrm_hold.sv */
// hold stage: keeps the newest sample set until no serial transaction runs
// assumes busy comes from the serial engines on the same clock
`timescale 1ns/100ps
`default_nettype none
module acrm_hold
    import acrm_pkg::*;
(
    // clock and reset
    input  wire logic                clk_in,
    input  wire logic                srst_in,
    // transaction state and new sample set
    input  wire logic                busy_in,
    input  wire logic                smp_valid_in,
    input  wire logic [SAMPLE_W-1:0] x_in,
    input  wire logic [SAMPLE_W-1:0] y_in,
    input  wire logic [SAMPLE_W-1:0] z_in,
    input  wire logic [BYTE_W-1:0]   evt_in,
    input  wire logic [BYTE_W-1:0]   pend_in,
    // held update towards the register bank
    acrm_upd_if.src                  upd
);
    import acrm_pkg::*;

    acrm_hold_t                  state_reg, state_next;
    logic [3*SAMPLE_W+2*BYTE_W-1:0] stage_reg, stage_next;

    // newest set overwrites the stage; release only while no transaction runs
    always_comb begin
        stage_next = stage_reg;
        state_next = state_reg;
        if (smp_valid_in) begin
            stage_next = {x_in, y_in, z_in, evt_in, pend_in};
            state_next = HOLD_PENDING;
        end else begin
            case (state_reg)
                HOLD_IDLE:    state_next = HOLD_IDLE;
                HOLD_PENDING: if (!busy_in) state_next = HOLD_IDLE;
                default:      state_next = HOLD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_reg <= HOLD_IDLE;
            stage_reg <= '0;
        end else begin
            state_reg <= state_next;
            stage_reg <= stage_next;
        end
    end

    // release pulse; a stop between sample periods gives it a chance to fire
    assign upd.apply = (state_reg == HOLD_PENDING) && !busy_in;
    assign {upd.x_smp, upd.y_smp, upd.z_smp, upd.evt, upd.pend} = stage_reg;

    property p_no_apply_busy;
        @(posedge clk_in) disable iff (srst_in) busy_in |-> !upd.apply;
    endproperty
    a_no_apply_busy: assert property (p_no_apply_busy) else $error("update released during transaction");

    sequence s_new_while_busy;
        smp_valid_in && busy_in;
    endsequence
    property p_release_after_busy;
        @(posedge clk_in) disable iff (srst_in)
        s_new_while_busy ##1 (!busy_in && !smp_valid_in) |-> upd.apply;
    endproperty
    a_release_after_busy: assert property (p_release_after_busy) else $error("held update not released");
endmodule
`default_nettype wire

/* File: tb/acrm_host.sv */
// host side model driving the register access port of the bank
// assumes the bank samples on the rising edge, so all changes land at the falling edge
`timescale 1ns/100ps
`default_nettype none
module acrm_host (
    // clock
    input  wire logic       clk_in,
    // access port towards the bank
    output logic            busy_out,
    output logic            load_out,
    output logic [7:0]      addr_out,
    output logic            wr_out,
    output logic [7:0]      wdata_out,
    output logic            rd_out,
    input  wire logic [7:0] rdata_in,
    input  wire logic       rvalid_in
);
    // idle port at time zero
    initial begin
        {busy_out, load_out, wr_out, rd_out} = 4'h0;
        addr_out = 8'h00;
        wdata_out = 8'h00;
    end
    // open a transaction and load the pointer
    task automatic start(input logic [7:0] a);
        @(negedge clk_in);
        busy_out = 1'b1;
        load_out = 1'b1;
        addr_out = a;
        @(negedge clk_in);
        load_out = 1'b0;
        addr_out = ~a;  // stale address must not be used
    endtask
    // one data byte written at the pointer
    task automatic wr_byte(input logic [7:0] d);
        @(negedge clk_in);
        wr_out = 1'b1;
        wdata_out = d;
        @(negedge clk_in);
        wr_out = 1'b0;
        wdata_out = ~d;  // data no longer qualified
    endtask
    // one byte fetched at the pointer, answer seen one cycle later
    task automatic rd_byte(output logic [7:0] d, output logic v);
        @(negedge clk_in);
        rd_out = 1'b1;
        @(negedge clk_in);
        rd_out = 1'b0;
        d = rdata_in;
        v = rvalid_in;
    endtask
    // close the transaction and stay idle for a cycle
    task automatic stop();
        @(negedge clk_in);
        busy_out = 1'b0;
        @(negedge clk_in);
    endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the accelerometer register bank
// assumes the host model in acrm_host and the bank defaults
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import acrm_pkg::*;
    logic                clk_in = 1'b0;
    logic                srst_in = 1'b1;
    logic                busy, load, wr, rd, rvalid, v;
    logic [7:0]          addr, wdata, rdata, d;
    logic                smp_valid = 1'b0;
    logic                wdt = 1'b0;
    logic                otp = 1'b0;
    logic [SAMPLE_W-1:0] xs = '0, ys = '0, zs = '0;
    logic [BYTE_W-1:0]   evt = '0, pend = '0, ie, ps, rs, mc, rf, xo;
    logic [1:0]          ff = '0;
    logic [FIDX_W-1:0]   fr = '0, fw = '0;
    int                  err_total = 0;
    int                  checked = 0;
    // 200 MHz clock
    always #2.5 clk_in = ~clk_in;
    acrm_host host (.clk_in(clk_in), .busy_out(busy), .load_out(load), .addr_out(addr),
        .wr_out(wr), .wdata_out(wdata), .rd_out(rd), .rdata_in(rdata), .rvalid_in(rvalid));
    acrm_regs dut (.clk_in(clk_in), .srst_in(srst_in), .acc_busy_in(busy),
        .acc_addr_load_in(load), .acc_addr_in(addr), .acc_wr_in(wr), .acc_wdata_in(wdata),
        .acc_rd_in(rd), .acc_rdata_out(rdata), .acc_rvalid_out(rvalid),
        .smp_valid_in(smp_valid), .x_axis_sample_in(xs), .y_axis_sample_in(ys),
        .z_axis_sample_in(zs), .evt_flags_in(evt), .int_pend_in(pend), .fifo_flags_in(ff),
        .fifo_rd_idx_in(fr), .fifo_wr_idx_in(fw), .wdt_event_in(wdt), .otp_busy_in(otp),
        .intr_enable_out(ie), .power_state_out(ps), .rate_select_out(rs),
        .motion_ctrl_out(mc), .range_filter_out(rf), .x_offset_low_out(xo));
    // compare and count
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // read one byte inside an open transaction
    task automatic rd_chk(input string nm, input logic [7:0] exp);
        host.rd_byte(d, v);
        check("rvalid", {7'h00, v}, 8'h01);
        check(nm, d, exp);
    endtask
    // single register write
    task automatic wr1(input logic [7:0] a, input logic [7:0] dat);
        host.start(a);
        host.wr_byte(dat);
        host.stop();
    endtask
    // single register read
    task automatic rd1(input logic [7:0] a, input logic [7:0] exp);
        host.start(a);
        rd_chk("rd1", exp);
        host.stop();
    endtask
    // one new sample set from the core
    task automatic push(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
        @(negedge clk_in);
        {xs, ys, zs, smp_valid} = {x, y, z, 1'b1};
        @(negedge clk_in);
        smp_valid = 1'b0;
    endtask
    // reset values, identity and reserved places
    task automatic t_reset();
        host.start(ADDR_DEVICE_STATUS);
        for (int i = 5; i <= 20; i++) rd_chk("reset", 8'h00);
        host.stop();
        rd1(ADDR_PART_IDENTIFIER, 8'h5A);
        rd1(8'h00, 8'h00);
        rd1(8'h15, 8'h00);
        $display("test reset done");
    endtask
    // burst writes, write masks and the wake lock
    task automatic t_write();
        host.start(ADDR_EVENT_INT_ENABLE);
        repeat (4) host.wr_byte(8'hFF);
        host.stop();
        check("intr", ie, 8'hDF);
        check("power", ps, 8'h33);
        check("rate", rs, 8'h07);
        check("motion", mc, 8'hFF);
        wr1(ADDR_FULL_SCALE_SEL, 8'hFF);
        check("range", rf, 8'h7F);
        wr1(ADDR_X_OFFSET_LOW, 8'hA5);
        check("xoff", xo, 8'hA5);
        wr1(ADDR_POWER_STATE_CTRL, 8'h01);
        check("wake", ps, 8'h01);
        wr1(ADDR_OUTPUT_RATE_SEL, 8'h02);
        check("locked", rs, 8'h07);
        wr1(ADDR_POWER_STATE_CTRL, 8'h00);
        wr1(ADDR_OUTPUT_RATE_SEL, 8'h02);
        check("standby", rs, 8'h02);
        $display("test write done");
    endtask
    // sample bytes, pairing and freeze during a transaction
    task automatic t_sample();
        evt = 8'h77;
        pend = 8'h88;
        push(16'h1122, 16'h3344, 16'h5566);
        host.start(ADDR_X_SAMPLE_LOW);
        rd_chk("xlo", 8'h22);
        rd_chk("xhi", 8'h11);
        rd_chk("ylo", 8'h44);
        rd_chk("yhi", 8'h33);
        rd_chk("zlo", 8'h66);
        rd_chk("zhi", 8'h55);
        rd_chk("evt", 8'h77);
        rd_chk("pend", 8'h88);
        host.stop();
        host.start(ADDR_Y_SAMPLE_LOW);
        rd_chk("ylo", 8'h44);
        evt = 8'h01;
        push(16'h0000, 16'h9999, 16'h7777);
        rd_chk("yhi_held", 8'h33);
        rd_chk("zlo_held", 8'h66);
        // newer set arrives in the last busy cycle, overwrites the pending one
        fork
            push(16'h0000, 16'hAABB, 16'hCCDD);
            begin
                @(negedge clk_in);
                host.stop();
            end
        join
        wr1(ADDR_Y_SAMPLE_LOW, 8'h00);
        host.start(ADDR_Y_SAMPLE_LOW);
        rd_chk("ylo_new", 8'hBB);
        rd_chk("yhi_new", 8'hAA);
        host.stop();
        rd1(ADDR_EVENT_FLAGS, 8'h01);
        $display("test sample done");
    endtask
    // device status, watchdog flag and fifo copies
    task automatic t_status();
        @(negedge clk_in);
        {ff, fr, fw, otp, wdt} = {2'h2, 6'h3F, 6'h15, 1'b1, 1'b1};
        @(negedge clk_in);
        wdt = 1'b0;
        wr1(ADDR_POWER_STATE_CTRL, 8'h01);
        rd1(ADDR_DEVICE_STATUS, 8'h91);
        rd1(ADDR_DEVICE_STATUS, 8'h81);
        // watchdog event in the same cycle as the clearing read: set wins
        host.start(ADDR_DEVICE_STATUS);
        fork
            rd_chk("clr", 8'h81);
            begin
                @(negedge clk_in);
                wdt = 1'b1;
                @(negedge clk_in);
                wdt = 1'b0;
            end
        join
        host.stop();
        rd1(ADDR_DEVICE_STATUS, 8'h91);
        host.start(ADDR_FIFO_LEVEL_FLAGS);
        rd_chk("fifo", 8'h02);
        rd_chk("rdidx", 8'h3F);
        rd_chk("wridx", 8'h15);
        host.stop();
        wr1(ADDR_POWER_STATE_CTRL, 8'h00);
        $display("test status done");
    endtask
    // counts and verdict
    task automatic stop_test();
        $display("checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (16) @(negedge clk_in);
        srst_in = 1'b0;
        t_reset();
        t_write();
        t_sample();
        t_status();
        stop_test();
    end
    // hang guard
    initial begin
        #100000;
        err_total++;
        stop_test();
    end
endmodule
`default_nettype wire
